// ==== hdl/sem_host_regs.svh ====
// timing counts and pin constants for the semaphore port controller
`ifndef SEM_HOST_REGS_SVH
`define SEM_HOST_REGS_SVH

`define SH_CLK_PERIOD_NS  20
`define SH_ACCESS_NS      55
`define SH_RECOVER_NS     40
`define SH_SYNC_CYC       4
`define SH_ACCESS_CYC     ((`SH_ACCESS_NS + `SH_CLK_PERIOD_NS - 1) / `SH_CLK_PERIOD_NS)
`define SH_RECOVER_CYC    ((`SH_RECOVER_NS + `SH_CLK_PERIOD_NS - 1) / `SH_CLK_PERIOD_NS)
`define SH_READ_CYC       (`SH_ACCESS_CYC + `SH_SYNC_CYC)
`define SH_DATA_TAKE      8'h00
`define SH_DATA_FREE      8'hFF
`define SH_OP_REQUEST     1'b0
`define SH_OP_RELEASE     1'b1

`endif

// ==== hdl/sem_host_pkg.sv ====
// types of the semaphore port controller
package sem_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WRITE = 3'b010,
    ST_WHOLD = 3'b011,
    ST_GAP   = 3'b100,
    ST_READ  = 3'b101,
    ST_CHECK = 3'b110,
    ST_RESP  = 3'b111
  } state_e;

  typedef struct packed {
    state_e     state;       // sequencer state
    logic [3:0] cnt;         // cycle counter
    logic       op;          // 0 request, 1 release
    logic [2:0] flag;        // flag being worked on
    logic [7:0] rd_val;      // captured read value
    logic       sel_n;       // flag select pin, low active
    logic       we_n;        // write enable pin, low active
    logic       oe_n;        // output enable pin, low active
    logic [2:0] addr;        // address pins
    logic [7:0] dout;        // data driven on writes
    logic       doe;         // data output enable
    logic       cmd_ready;   // ready for a command
    logic       rsp_valid;   // answer pulse
    logic       rsp_granted; // token held after command
    logic       rsp_error;   // data lines disagreed
    logic [7:0] held;        // flags held by this port
  } ctl_s;

endpackage : sem_host_pkg

// ==== hdl/sem_pin_sync.sv ====
// three-stage synchroniser with agreement filter for the data pins
module sem_pin_sync (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] sync_out
);

  logic [7:0] s1_r;   // first stage, read only by s2_r
  logic [7:0] s2_r;   // second stage
  logic [7:0] s3_r;   // third stage

  // shift pins in; output follows once stages two and three agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r     <= 8'hFF;
      s2_r     <= 8'hFF;
      s3_r     <= 8'hFF;
      sync_out <= 8'hFF;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end

endmodule : sem_pin_sync

// ==== hdl/sem_host.sv ====
// controller driving one port of a dual-port semaphore flag block
`include "sem_host_regs.svh"

module sem_host
  import sem_host_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_op,
  input  wire logic [2:0] cmd_flag,
  input  wire logic       cmd_abort,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic            rsp_granted,
  output logic            rsp_error,
  output logic      [7:0] held_flags,
  output logic            pin_sel_n,
  output logic            pin_we_n,
  output logic            pin_oe_n,
  output logic      [2:0] pin_addr,
  input  wire logic [7:0] pin_data_in,
  output logic      [7:0] pin_data_out,
  output logic            pin_data_oe
);

  ctl_s       r;      // registered state
  ctl_s       n;      // next state
  logic [7:0] din_s;  // synchronised data pins

  // data pins pass the synchroniser before use
  sem_pin_sync u_sync (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .pin_in   (pin_data_in),
    .sync_out (din_s)
  );

  // next-state logic of the access sequencer
  always_comb begin
    n           = r;
    n.rsp_valid = 1'b0;
    case (r.state)
      ST_IDLE: begin
        // take a command and open the flag select
        if (cmd_valid && r.cmd_ready) begin
          n.cmd_ready = 1'b0;
          n.op        = cmd_op;
          n.flag      = cmd_flag;
          n.addr      = cmd_flag;
          n.sel_n     = 1'b0;
          // request writes zero, release writes one
          n.dout      = (cmd_op == `SH_OP_RELEASE) ? `SH_DATA_FREE : `SH_DATA_TAKE;
          n.state     = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // address settled, start the write strobe
        n.we_n  = 1'b0;
        n.doe   = 1'b1;
        n.cnt   = 4'(`SH_ACCESS_CYC - 1);
        n.state = ST_WRITE;
      end
      ST_WRITE: begin
        // hold write strobe for the access time
        if (r.cnt == 4'h0) begin
          n.we_n  = 1'b1;
          n.state = ST_WHOLD;
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      ST_WHOLD: begin
        // data held one cycle past strobe, then close select
        n.doe   = 1'b0;
        n.sel_n = 1'b1;
        n.cnt   = 4'(`SH_RECOVER_CYC - 1);
        n.state = ST_GAP;
      end
      ST_GAP: begin
        // select and enable stay high before the next read
        if (r.cnt != 4'h0) begin
          n.cnt = r.cnt - 4'h1;
        end else if (r.op == `SH_OP_RELEASE) begin
          n.held[r.flag] = 1'b0;
          n.rsp_granted  = 1'b0;
          n.rsp_error    = 1'b0;
          n.state        = ST_RESP;
        end else begin
          n.sel_n = 1'b0;
          n.oe_n  = 1'b0;
          n.cnt   = 4'(`SH_READ_CYC - 1);
          n.state = ST_READ;
        end
      end
      ST_READ: begin
        // read strobe covers access time and synchroniser delay
        if (r.cnt == 4'h0) begin
          n.rd_val = din_s;
          n.oe_n   = 1'b1;
          n.sel_n  = 1'b1;
          n.state  = ST_CHECK;
        end else begin
          n.cnt = r.cnt - 4'h1;
        end
      end
      ST_CHECK: begin
        // judge the read value
        if (r.rd_val == `SH_DATA_TAKE) begin
          n.held[r.flag] = 1'b1;
          n.rsp_granted  = 1'b1;
          n.rsp_error    = 1'b0;
          n.state        = ST_RESP;
        end else if (r.rd_val != `SH_DATA_FREE) begin
          // lines disagree: report, do not claim the token
          n.rsp_granted = 1'b0;
          n.rsp_error   = 1'b1;
          n.state       = ST_RESP;
        end else if (cmd_abort) begin
          // user gave up waiting; request stays posted in the device
          n.rsp_granted = 1'b0;
          n.rsp_error   = 1'b0;
          n.state       = ST_RESP;
        end else begin
          // other port holds it: read again after a gap
          n.cnt   = 4'(`SH_RECOVER_CYC - 1);
          n.state = ST_GAP;
        end
      end
      ST_RESP: begin
        // answer pulse, back to idle
        n.rsp_valid = 1'b1;
        n.cmd_ready = 1'b1;
        n.state     = ST_IDLE;
      end
      default: begin
        n.state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      r             <= '0;
      r.state       <= ST_IDLE;
      r.rd_val      <= 8'hFF;
      r.sel_n       <= 1'b1;
      r.we_n        <= 1'b1;
      r.oe_n        <= 1'b1;
      r.dout        <= 8'hFF;
      r.cmd_ready   <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // outputs come straight from the state register
  assign cmd_ready    = r.cmd_ready;
  assign rsp_valid    = r.rsp_valid;
  assign rsp_granted  = r.rsp_granted;
  assign rsp_error    = r.rsp_error;
  assign held_flags   = r.held;
  assign pin_sel_n    = r.sel_n;
  assign pin_we_n     = r.we_n;
  assign pin_oe_n     = r.oe_n;
  assign pin_addr     = r.addr;
  assign pin_data_out = r.dout;
  assign pin_data_oe  = r.doe;

  // a write strobe of a request carries zero
  property p_req_zero;
    @(posedge mclk) disable iff (!reset_n)
      (!pin_we_n && r.op == `SH_OP_REQUEST) |-> (pin_data_oe && pin_data_out == 8'h00 && !pin_sel_n);
  endproperty
  a_req_zero: assert property (p_req_zero) else $error("request write not zero");

  // a write strobe of a release carries all ones
  property p_rel_one;
    @(posedge mclk) disable iff (!reset_n)
      (!pin_we_n && r.op == `SH_OP_RELEASE) |-> (pin_data_oe && pin_data_out == 8'hFF);
  endproperty
  a_rel_one: assert property (p_rel_one) else $error("release write not one");

  // a grant is reported only after a zero was read
  property p_grant_on_zero;
    @(posedge mclk) disable iff (!reset_n)
      (rsp_valid && rsp_granted) |-> (r.rd_val == 8'h00 && held_flags[r.flag]);
  endproperty
  a_grant_on_zero: assert property (p_grant_on_zero) else $error("grant without zero read");

  // read strobe ends then select and enable stay high for two cycles
  sequence s_read_end;
    $rose(pin_oe_n);
  endsequence
  sequence s_idle_two;
    (pin_oe_n && pin_sel_n) [*2];
  endsequence
  property p_read_gap;
    @(posedge mclk) disable iff (!reset_n)
      s_read_end |-> s_idle_two;
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("no gap between reads");

  // a read strobe lasts the whole access plus synchroniser time
  property p_read_len;
    @(posedge mclk) disable iff (!reset_n)
      $fell(pin_oe_n) |-> (!pin_oe_n && !pin_sel_n) [*7];
  endproperty
  a_read_len: assert property (p_read_len) else $error("read strobe too short");

  // every accepted command reaches the pins promptly
  sequence s_accept;
    cmd_valid && cmd_ready;
  endsequence
  property p_reach_pins;
    @(posedge mclk) disable iff (!reset_n)
      s_accept |-> ##1 !pin_sel_n ##1 !pin_we_n [*3] ##1 pin_we_n;
  endproperty
  a_reach_pins: assert property (p_reach_pins) else $error("access did not reach pins");

endmodule : sem_host

// ==== verif/sem_flag_dev.sv ====
// behavioural dual-port semaphore flag device
module sem_flag_dev (
  input  wire logic       reset_n,
  input  wire logic       sel_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] din,
  output logic      [7:0] dout,
  input  wire logic       b_wr,
  input  wire logic [2:0] b_flag,
  input  wire logic       b_val,
  input  wire logic       bad_read,
  output logic      [7:0] b_own
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] a_req, b_req, a_own; // request flops, owner of port a
  logic [7:0] last;                // value latched by the read

  // a write of one frees, zero posts a request; waiting side takes over
  task automatic put(input bit side, input int f, input bit v);
    if (side) b_req[f] = !v;
    else a_req[f] = !v;
    if (v && side) b_own[f] = 1'b0;
    if (v && !side) a_own[f] = 1'b0;
    if (a_req[f] && !b_own[f]) a_own[f] = 1'b1;
    if (b_req[f] && !a_own[f]) b_own[f] = 1'b1;
  endtask : put

  // port a writes at the end of its strobe, bit zero only
  always @(posedge we_n) if (!sel_n && reset_n) put(0, addr, din[0]);
  always @(posedge b_wr) put(1, b_flag, b_val);
  // every flag free after reset
  always @(negedge reset_n) begin
    {a_req, b_req, a_own, b_own} = '0;
    last = 8'hFF;
  end
  // same state at time zero, should the first reset edge come before this model waits for it
  initial begin
    {a_req, b_req, a_own, b_own} = '0;
    last = 8'hFF;
  end
  // read value frozen while select and enable stay low
  always @(negedge sel_n or negedge oe_n)
    if (!sel_n && !oe_n) last = (a_own[addr] ? 8'h00 : 8'hFF) ^ {7'h00, bad_read};
  // released lines show the inverse of the last value
  assign dout = (!sel_n && !oe_n && we_n) ? last : ~last;
endmodule : sem_flag_dev

// ==== verif/sem_host_test.sv ====
// self-checking bench for the semaphore port controller
module sem_host_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, reset_n, cmd_valid, cmd_op, cmd_abort;
  logic       b_wr, b_val, bad_read, cmd_ready, rsp_valid;
  logic       rsp_granted, rsp_error, sel_n, we_n, oe_n, data_oe;
  logic [2:0] cmd_flag, b_flag, addr, f;
  logic [7:0] held_flags, b_own, data_out, dev_out, bus, exp_held;
  int         err_count, compares, cyc;

  // shared data wire: host drives on writes, device otherwise
  assign bus = data_oe ? data_out : dev_out;

  sem_host sem_host_i (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_flag(cmd_flag), .cmd_abort(cmd_abort), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_granted(rsp_granted), .rsp_error(rsp_error), .held_flags(held_flags), .pin_sel_n(sel_n),
    .pin_we_n(we_n), .pin_oe_n(oe_n), .pin_addr(addr), .pin_data_in(bus), .pin_data_out(data_out),
    .pin_data_oe(data_oe));
  sem_flag_dev sem_flag_dev_i (.reset_n(reset_n), .sel_n(sel_n), .we_n(we_n), .oe_n(oe_n),
    .addr(addr), .din(bus), .dout(dev_out), .b_wr(b_wr), .b_flag(b_flag), .b_val(b_val),
    .bad_read(bad_read), .b_own(b_own));

  // 50 MHz clock
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // verdict and end of run
  task automatic test_done();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  // compare one value and count it
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // expected held set after one request or release of flag fl
  function automatic logic [7:0] next_held(input logic [7:0] h, input logic [2:0] fl);
    return h ^ (8'h01 << fl);
  endfunction : next_held

  // one command, then wait for its answer pulse
  task automatic cmd(input logic op, input logic [2:0] fl, input logic ab, input logic g, input logic e);
    int n;
    cmd_op = op;
    cmd_flag = fl;
    cmd_abort = ab;
    cmd_valid = 1'b1;
    @(posedge mclk) #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge mclk) #1;
      n++;
    end
    check("answer", rsp_valid, 1'b1);
    check("granted", rsp_granted, g);
    check("error", rsp_error, e);
    @(posedge mclk) #1;
  endtask : cmd

  // other port writes a flag
  task automatic b_put(input logic [2:0] fl, input logic v);
    b_flag = fl;
    b_val = v;
    b_wr = 1'b1;
    @(posedge mclk) #1;
    b_wr = 1'b0;
    @(posedge mclk) #1;
  endtask : b_put

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end

  // main sequence
  initial begin
    {reset_n, cmd_valid, cmd_op, cmd_abort, b_wr, b_val, bad_read} = '0;
    {cmd_flag, b_flag} = '0;
    void'($urandom(32'h425C));
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b1;
    check("held", held_flags, 8'h00);
    check("ready", cmd_ready, 1'b1);
    // free flag granted, other port then locked out
    cmd(0, 3, 0, 1, 0);
    b_put(3, 0);
    check("b owner", b_own, 8'h00);
    cmd(1, 3, 0, 0, 0);
    check("b owner", b_own, 8'h08);
    // other side holds: keep re-reading until it lets go
    fork
      cmd(0, 3, 0, 1, 0);
      begin
        repeat (80) @(posedge mclk);
        #1 b_put(3, 1);
      end
    join
    check("held", held_flags, 8'h08);
    cmd(1, 3, 0, 0, 0);
    // abort a denied request, then withdraw it
    b_put(5, 0);
    cmd(0, 5, 1, 0, 0);
    b_put(5, 1);
    cmd(1, 5, 0, 0, 0);
    check("b owner", b_own, 8'h00);
    // mixed data lines reported as error
    bad_read = 1'b1;
    cmd(0, 6, 0, 0, 1);
    bad_read = 1'b0;
    cmd(1, 6, 0, 0, 0);
    // every flag, then random requests and releases
    exp_held = 8'h00;
    for (int i = 0; i < 24; i++) begin
      f = (i < 8) ? 3'(i) : 3'($urandom_range(7));
      cmd(exp_held[f], f, 0, !exp_held[f], 0);
      exp_held = next_held(exp_held, f);
      check("held", held_flags, exp_held);
    end
    // reset in mid-run frees every flag on both sides
    b_put(2, 0);
    reset_n = 1'b0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    check("held", held_flags, 8'h00);
    check("b owner", b_own, 8'h00);
    check("ready", cmd_ready, 1'b1);
    cmd(0, 2, 0, 1, 0);
    cmd(1, 2, 0, 0, 0);
    check("held", held_flags, 8'h00);
    test_done();
  end
endmodule : sem_host_test
